// *** src/pdm_pkg.sv ***
// Package: register map, fields, status codes and timing for the power-down controller
package pdm_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] STANDBY_CONTROL_ADDR  = 8'h82;
	localparam logic [7:0] WAKE_STATUS_ADDR      = 8'h84;
	localparam logic [7:0] STANDBY_CONTROL_RESET = 8'h00;
	localparam logic [7:0] STANDBY_CONTROL_MASK  = 8'h87;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int DEEP_HALT_SELECT_BIT = 7;
	localparam int TIMER_STOP_BIT       = 2;
	localparam int CALENDAR_STOP_BIT    = 1;
	localparam int SERIAL_STOP_BIT      = 0;

	// ----------------------------------------------------------------
	// Status pin codes {hi, lo}
	// ----------------------------------------------------------------
	localparam logic [1:0] STATE_CODE_RESET   = 2'h3;
	localparam logic [1:0] STATE_CODE_SLEEP   = 2'h2;
	localparam logic [1:0] STATE_CODE_STANDBY = 2'h1;
	localparam logic [1:0] STATE_CODE_NORMAL  = 2'h0;

	// ----------------------------------------------------------------
	// Interrupt event codes and widths
	// ----------------------------------------------------------------
	localparam int          EVENT_CODE_WIDTH   = 12;
	localparam logic [11:0] EVENT_CODE_NMI     = 12'h1C0;
	localparam logic [11:0] EVENT_CODE_LEVEL   = 12'h200;
	localparam logic [11:0] EVENT_CODE_PERIPH  = 12'h400;
	localparam logic [11:0] EVENT_CODE_NONE    = 12'h000;
	localparam int          SETTLE_COUNT_WIDTH = 16;

	typedef enum {
		PDM_RUN,
		PDM_SLEEP,
		PDM_STANDBY,
		PDM_SETTLE
	} pdm_mode_type;

	typedef struct packed {
		logic timerStop;
		logic calendarStop;
		logic serialStop;
	} pdm_module_stop_type;

	typedef struct packed {
		logic nmi;
		logic [3:0] level;
		logic periph;
		logic intervalTimer;
	} pdm_irq_type;

endpackage : pdm_pkg

// *** src/pdm_settle_timer.sv ***
// Settling counter: counts down the loaded settle time on peripheral-clock enables
module pdm_settle_timer #(
	parameter int WIDTH = pdm_pkg::SETTLE_COUNT_WIDTH
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset_n,
	// Control
	input  wire logic             start,
	input  wire logic [WIDTH-1:0] loadValue,
	input  wire logic             tick,
	// Result
	output logic                  done
);

	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	logic             running;
	logic             next_running;
	logic             next_done;

	always_comb begin
		next_count   = count;
		next_running = running;
		next_done    = 1'b0;
		if (start) begin
			next_count   = loadValue;
			next_running = 1'b1;
		end else if (running && tick) begin
			if (count == '0) begin
				next_running = 1'b0;
				next_done    = 1'b1;
			end else begin
				next_count = count - WIDTH'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count   <= '0;
			running <= 1'b0;
			done    <= 1'b0;
		end else begin
			count   <= next_count;
			running <= next_running;
			done    <= next_done;
		end
	end

endmodule : pdm_settle_timer

// *** src/pdm_power_down_mode_control.sv ***
// Power-down mode controller: standby control register, status pins, clock gating, wake
// Operation
// - Sleep shows status code high-low
// - Refresh during sleep shows normal code
// - Reset shows high-high, normal shows low-low
// - Standby with clocks halted shows low-high
// - Control register is 8 bits, power-on clears
// - Manual reset keeps control register contents
// - Bits six to three read zero
// - Bit 7 picks sleep or standby
// - Bit 2 stops timer unit clock
// - Bit 1 stops calendar register clock, blocks access
// - Bit 0 stops serial port clock
// - Clear bit or any reset ends module stop (manual reset only forces it off while held; the kept bits restart it)
// - Sleep halts CPU, peripherals and bus clock run
// - Interrupts or reset end sleep, ignoring block bit
// - Interrupt wake loads event code, starts handling
// - Standby stops CPU, clocks, peripherals, bus clock
// - Standby entry clears timer start register
// - Standby wake waits settle time, then resumes
// - Level wake needs level above mask
//
// Implementation choices: the strobed register port and the placing of the registers.
module pdm_power_down_mode_control #(
	parameter int PERIPH_DIVIDE = 4
) (
	// Clock and resets
	input  wire logic                                   clk,
	input  wire logic                                   reset_n,
	input  wire logic                                   manualReset_n,
	// Register port
	input  wire logic [7:0]                             regAddr,
	input  wire logic [7:0]                             regWriteData,
	input  wire logic                                   regWrite,
	input  wire logic                                   regRead,
	output logic      [7:0]                             regReadData,
	// CPU side
	input  wire logic                                   sleepInstruction,
	input  wire logic [3:0]                             interruptMaskLevel,
	input  wire logic                                   blockBit,
	input  wire logic                                   refreshCycle,
	input  wire pdm_pkg::pdm_irq_type                   irq,
	input  wire logic [pdm_pkg::SETTLE_COUNT_WIDTH-1:0] settleCount,
	output logic                                        cpuHalt,
	output logic                                        interruptStart,
	output logic      [pdm_pkg::EVENT_CODE_WIDTH-1:0]   interruptEventCode,
	// Clock gating
	output logic                                        internalClockEnable,
	output logic                                        busClockEnable,
	output logic                                        peripheralEnable,
	output pdm_pkg::pdm_module_stop_type                moduleStop,
	output logic                                        calendarAccessBlock,
	output logic                                        timerStartClear,
	// Status pins
	output logic                                        procStateHiPin,
	output logic                                        procStateLoPin
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	pdm_pkg::pdm_mode_type        mode;
	pdm_pkg::pdm_mode_type        next_mode;
	logic [7:0]                   standbyControl;
	logic [7:0]                   next_standbyControl;
	logic [7:0]                   next_regReadData;
	logic [11:0]                  pendingCode;
	logic [11:0]                  next_pendingCode;
	logic [11:0]                  next_interruptEventCode;
	logic                         next_interruptStart;
	logic [1:0]                   next_stateCode;
	logic [1:0]                   stateCode;
	logic [7:0]                   divCount;
	logic [7:0]                   next_divCount;
	logic                         periphTick;
	logic                         settleStart;
	logic                         settleDone;
	logic                         levelWake;
	logic                         sleepWake;
	logic                         standbyWake;
	logic [11:0]                  wakeCode;
	logic                         haltedClocks;
	logic                         next_cpuHalt;
	logic                         next_clockEnable;
	logic                         next_peripheralEnable;
	logic                         next_calendarAccessBlock;
	logic                         next_timerStartClear;
	pdm_pkg::pdm_module_stop_type next_moduleStop;

	// ----------------------------------------------------------------
	// Peripheral divider
	// ----------------------------------------------------------------
	// Peripheral-rate enable; the settle count runs on it
	always_comb begin
		next_divCount = divCount + 8'h01;
		if (divCount == 8'(PERIPH_DIVIDE - 1)) begin
			next_divCount = 8'h00;
		end
	end
	assign periphTick = (divCount == 8'(PERIPH_DIVIDE - 1));

	// ----------------------------------------------------------------
	// Wake qualification
	// ----------------------------------------------------------------
	// Block bit is deliberately not an input to either term
	assign levelWake   = (irq.level > interruptMaskLevel);
	assign sleepWake   = irq.nmi || levelWake || irq.periph;
	// The interval timer cannot run while the clocks are halted, so it cannot wake standby
	assign standbyWake = irq.nmi || levelWake || (irq.periph && !irq.intervalTimer);

	always_comb begin
		wakeCode = pdm_pkg::EVENT_CODE_PERIPH;
		if (irq.nmi) begin
			wakeCode = pdm_pkg::EVENT_CODE_NMI;
		end else if (levelWake) begin
			wakeCode = pdm_pkg::EVENT_CODE_LEVEL;
		end
	end

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	always_comb begin
		next_standbyControl = standbyControl;
		next_regReadData    = 8'h00;
		if (regWrite && regAddr == pdm_pkg::STANDBY_CONTROL_ADDR) begin
			next_standbyControl = regWriteData & pdm_pkg::STANDBY_CONTROL_MASK;
		end
		if (regRead) begin
			if (regAddr == pdm_pkg::STANDBY_CONTROL_ADDR) begin
				next_regReadData = standbyControl & pdm_pkg::STANDBY_CONTROL_MASK;
			end else if (regAddr == pdm_pkg::WAKE_STATUS_ADDR) begin
				next_regReadData = {6'h00, stateCode};
			end else begin
				next_regReadData = 8'h00;
			end
		end
	end

	// ----------------------------------------------------------------
	// Mode sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_mode               = mode;
		next_pendingCode        = pendingCode;
		next_interruptStart     = 1'b0;
		next_interruptEventCode = interruptEventCode;
		settleStart             = 1'b0;
		case (mode)
			pdm_pkg::PDM_RUN: begin
				if (sleepInstruction) begin
					if (standbyControl[pdm_pkg::DEEP_HALT_SELECT_BIT]) begin
						next_mode = pdm_pkg::PDM_STANDBY;
					end else begin
						next_mode = pdm_pkg::PDM_SLEEP;
					end
				end
			end
			pdm_pkg::PDM_SLEEP: begin
				if (sleepWake) begin
					next_mode               = pdm_pkg::PDM_RUN;
					next_interruptStart     = 1'b1;
					next_interruptEventCode = wakeCode;
				end
			end
			pdm_pkg::PDM_STANDBY: begin
				if (standbyWake) begin
					next_mode        = pdm_pkg::PDM_SETTLE;
					next_pendingCode = wakeCode;
					settleStart      = 1'b1;
				end
			end
			pdm_pkg::PDM_SETTLE: begin
				if (settleDone) begin
					next_mode               = pdm_pkg::PDM_RUN;
					next_interruptStart     = 1'b1;
					next_interruptEventCode = pendingCode;
				end
			end
			default: begin
				next_mode = pdm_pkg::PDM_RUN;
			end
		endcase
		// Manual reset wins over any entry or wake decided above
		if (!manualReset_n) begin
			next_mode               = pdm_pkg::PDM_RUN;
			next_pendingCode        = pendingCode;
			next_interruptStart     = 1'b0;
			next_interruptEventCode = interruptEventCode;
			settleStart             = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Status code
	// ----------------------------------------------------------------
	// Registered so each change is one clean edge
	always_comb begin
		next_stateCode = pdm_pkg::STATE_CODE_NORMAL;
		case (next_mode)
			pdm_pkg::PDM_SLEEP: begin
				if (refreshCycle) begin
					next_stateCode = pdm_pkg::STATE_CODE_NORMAL;
				end else begin
					next_stateCode = pdm_pkg::STATE_CODE_SLEEP;
				end
			end
			pdm_pkg::PDM_STANDBY: next_stateCode = pdm_pkg::STATE_CODE_STANDBY;
			pdm_pkg::PDM_SETTLE:  next_stateCode = pdm_pkg::STATE_CODE_STANDBY;
			default:              next_stateCode = pdm_pkg::STATE_CODE_NORMAL;
		endcase
		if (!manualReset_n) begin
			next_stateCode = pdm_pkg::STATE_CODE_RESET;
		end
	end

	pdm_settle_timer #(
		.WIDTH(pdm_pkg::SETTLE_COUNT_WIDTH)
	) settleTimer (
		.clk      (clk),
		.reset_n  (reset_n),
		.start    (settleStart),
		.loadValue(settleCount),
		.tick     (periphTick),
		.done     (settleDone)
	);

	// ----------------------------------------------------------------
	// Output next values
	// ----------------------------------------------------------------
	// Internal clock keeps running under reset so the bus clock pin stays alive
	always_comb begin
		haltedClocks             = (next_mode == pdm_pkg::PDM_STANDBY)
			|| (next_mode == pdm_pkg::PDM_SETTLE);
		next_cpuHalt             = (next_mode != pdm_pkg::PDM_RUN);
		next_clockEnable         = !haltedClocks;
		next_peripheralEnable    = periphTick && manualReset_n && !haltedClocks;
		next_timerStartClear     = (mode == pdm_pkg::PDM_RUN)
			&& (next_mode == pdm_pkg::PDM_STANDBY);
		next_moduleStop.timerStop    = next_standbyControl[pdm_pkg::TIMER_STOP_BIT];
		next_moduleStop.calendarStop = next_standbyControl[pdm_pkg::CALENDAR_STOP_BIT];
		next_moduleStop.serialStop   = next_standbyControl[pdm_pkg::SERIAL_STOP_BIT];
		next_calendarAccessBlock = next_standbyControl[pdm_pkg::CALENDAR_STOP_BIT];
		if (!manualReset_n) begin
			next_moduleStop          = '0;
			next_calendarAccessBlock = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Control register only sees power-on reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			standbyControl <= pdm_pkg::STANDBY_CONTROL_RESET;
			regReadData    <= 8'h00;
			divCount       <= 8'h00;
		end else begin
			standbyControl <= next_standbyControl;
			regReadData    <= next_regReadData;
			divCount       <= next_divCount;
		end
	end

	// Manual reset is synchronous; it ends sleep and standby and holds module stop off while low
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mode                <= pdm_pkg::PDM_RUN;
			pendingCode         <= pdm_pkg::EVENT_CODE_NONE;
			interruptStart      <= 1'b0;
			interruptEventCode  <= pdm_pkg::EVENT_CODE_NONE;
			stateCode           <= pdm_pkg::STATE_CODE_RESET;
			cpuHalt             <= 1'b0;
			internalClockEnable <= 1'b1;
			busClockEnable      <= 1'b1;
			peripheralEnable    <= 1'b0;
			moduleStop          <= '0;
			calendarAccessBlock <= 1'b0;
			timerStartClear     <= 1'b0;
			procStateHiPin      <= 1'b1;
			procStateLoPin      <= 1'b1;
		end else begin
			mode                <= next_mode;
			pendingCode         <= next_pendingCode;
			interruptStart      <= next_interruptStart;
			interruptEventCode  <= next_interruptEventCode;
			stateCode           <= next_stateCode;
			procStateHiPin      <= next_stateCode[1];
			procStateLoPin      <= next_stateCode[0];
			cpuHalt             <= next_cpuHalt;
			internalClockEnable <= next_clockEnable;
			busClockEnable      <= next_clockEnable;
			peripheralEnable    <= next_peripheralEnable;
			moduleStop          <= next_moduleStop;
			calendarAccessBlock <= next_calendarAccessBlock;
			timerStartClear     <= next_timerStartClear;
		end
	end

endmodule : pdm_power_down_mode_control

// *** tb/pdm_sva.sv ***
// Checker: status code, register and clock gating relations of the controller
module pdm_sva (
	// Clock and resets
	input wire logic	clk,
	input wire logic	reset_n,
	input wire logic	manualReset_n,
	// Register port
	input wire logic [7:0]	regAddr,
	input wire logic [7:0]	regWriteData,
	input wire logic	regWrite,
	input wire logic	regRead,
	input wire logic [7:0]	regReadData,
	// CPU side
	input wire logic	sleepInstruction,
	input wire logic	refreshCycle,
	input wire pdm_pkg::pdm_irq_type	irq,
	input wire logic	cpuHalt,
	input wire logic	interruptStart,
	// Clock gating and status
	input wire logic	internalClockEnable,
	input wire logic	busClockEnable,
	input wire logic	peripheralEnable,
	input wire pdm_pkg::pdm_module_stop_type	moduleStop,
	input wire logic	timerStartClear,
	input wire logic	procStateHiPin,
	input wire logic	procStateLoPin
);
	timeunit 1ns;
	timeprecision 1ns;
	// One peripheral tick every four cycles at the default divide
	localparam int	SLEEP_TICK_SPAN = 3;
	logic [1:0]	pins;
	logic	sleeping;
	logic [7:0]	ctrlAddr;
	assign pins = {procStateHiPin, procStateLoPin};
	assign sleeping = cpuHalt && internalClockEnable;
	assign ctrlAddr = pdm_pkg::STANDBY_CONTROL_ADDR;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// --------
	// Relations
	// --------
	reset_code_a: assert property (!manualReset_n |=> pins == 2'h3)
		else $error("no reset code");
	sleep_code_a: assert property (sleeping && !$past(refreshCycle) |-> pins == 2'h2)
		else $error("no sleep code");
	refresh_code_a: assert property (sleeping && $past(refreshCycle) |-> pins == 2'h0)
		else $error("no normal code in refresh");
	standby_code_a: assert property (cpuHalt && !internalClockEnable |-> pins == 2'h1)
		else $error("no standby code");
	stop_bits_a: assert property (regWrite && regAddr == ctrlAddr && manualReset_n
		|=> moduleStop == 3'($past(regWriteData)))
		else $error("stop bits wrong");
	manual_stop_a: assert property (!manualReset_n |=> moduleStop == 3'h0)
		else $error("stop kept in reset");
	reserved_read_a: assert property (regRead && regAddr == ctrlAddr
		|=> regReadData[6:3] == 4'h0)
		else $error("reserved bits set");
	clock_gate_a: assert property (busClockEnable == internalClockEnable)
		else $error("bus clock mismatch");
	periph_halt_a: assert property (!internalClockEnable |-> !peripheralEnable)
		else $error("peripheral tick in standby");
	sleep_tick_a: assert property (sleeping |-> ##[0:SLEEP_TICK_SPAN]
		(peripheralEnable || !internalClockEnable || !manualReset_n))
		else $error("no peripheral tick in sleep");
	entry_clear_a: assert property (timerStartClear |-> pins == 2'h1 && cpuHalt)
		else $error("start clear outside entry");
	sleep_entry_a: assert property (sleepInstruction && !cpuHalt && manualReset_n
		|=> cpuHalt)
		else $error("no halt on sleep");
	sleep_wake_a: assert property (sleeping && irq.nmi && manualReset_n
		|=> interruptStart)
		else $error("no sleep wake");
	settle_bound_a: assert property (cpuHalt && !internalClockEnable && irq.nmi
		|-> ##[1:100] (interruptStart || !manualReset_n))
		else $error("no standby wake");
	refresh_c: cover property (sleeping && refreshCycle);
	standby_c: cover property (timerStartClear);
	wake_c: cover property (interruptStart && !$past(internalClockEnable));
endmodule : pdm_sva

bind pdm_power_down_mode_control pdm_sva pdm_sva_i (
	.clk, .reset_n, .manualReset_n, .regAddr, .regWriteData, .regWrite, .regRead,
	.regReadData, .sleepInstruction, .refreshCycle, .irq, .cpuHalt, .interruptStart,
	.internalClockEnable, .busClockEnable, .peripheralEnable, .moduleStop, .timerStartClear,
	.procStateHiPin, .procStateLoPin
);

// *** tb/pdm_irq_source.sv ***
// Partner model: interrupt sources that hold a request until it is serviced
module pdm_irq_source (
	// Clock and reset
	input wire logic	clk,
	input wire logic	reset_n,
	// Control from the bench
	input wire logic	fire,
	input wire logic	drop,
	input wire logic [1:0]	kind,
	input wire logic [3:0]	levelValue,
	// Device side
	input wire logic	interruptStart,
	output pdm_pkg::pdm_irq_type	irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic	active;
	// A real source keeps its level up until the handler takes it
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			active <= 1'b0;
		else if (fire)
			active <= 1'b1;
		else if (interruptStart || drop)
			active <= 1'b0;
	end
	always_comb begin
		irq = '0;
		if (active) begin
			irq.nmi = kind == 2'h0;
			irq.level = kind == 2'h1 ? levelValue : 4'h0;
			irq.periph = kind[1];
			irq.intervalTimer = kind == 2'h3;
		end
	end
endmodule : pdm_irq_source

// *** tb/power_down_mode_control_tb_top.sv ***
// Testbench: register, reset, sleep and standby scenarios against a bench model
module power_down_mode_control_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int	DIV = 4;
	logic	clk = 1'b0;
	logic	reset_n, manualReset_n, regWrite, regRead, sleepInstruction, blockBit;
	logic	refreshCycle, fire, drop, interruptStart, cpuHalt, internalClockEnable;
	logic	busClockEnable, calendarAccessBlock, procStateHiPin, procStateLoPin;
	logic [7:0]	regAddr, regWriteData, regReadData;
	logic [3:0]	interruptMaskLevel, levelValue;
	logic [1:0]	kind, pins;
	logic [15:0]	settleCount;
	logic [11:0]	interruptEventCode;
	logic [11:0]	code [3];
	pdm_pkg::pdm_irq_type	irq;
	pdm_pkg::pdm_module_stop_type	moduleStop;
	int	mismatches = 0, check_count = 0, cycles = 0, ctrl, n, s;
	assign pins = {procStateHiPin, procStateLoPin};

	pdm_power_down_mode_control #(.PERIPH_DIVIDE(DIV)) pdm_power_down_mode_control_i (
		.clk, .reset_n, .manualReset_n, .regAddr, .regWriteData, .regWrite, .regRead,
		.regReadData, .sleepInstruction, .interruptMaskLevel, .blockBit, .refreshCycle,
		.irq, .settleCount, .cpuHalt, .interruptStart, .interruptEventCode,
		.internalClockEnable, .busClockEnable, .peripheralEnable(), .moduleStop,
		.calendarAccessBlock, .timerStartClear(), .procStateHiPin, .procStateLoPin
	);
	pdm_irq_source pdm_irq_source_i (
		.clk, .reset_n, .fire, .drop, .kind, .levelValue, .interruptStart, .irq
	);

	always #50 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			report_and_stop();
		end
	end

	// --------
	// Tasks
	// --------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWriteData <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1 chk(regReadData, e);
	endtask : rd
	task automatic irqPulse(input logic [1:0] k, input logic [3:0] lv);
		@(posedge clk);
		kind <= k;
		levelValue <= lv;
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
	endtask : irqPulse
	task automatic runMode(input logic m, input logic [1:0] k);
		@(posedge clk);
		s = $urandom_range(6, 1);
		settleCount <= 16'(s);
		interruptMaskLevel <= 4'($urandom_range(13));
		blockBit <= 1'($urandom);
		ctrl = {m, 4'h0, 3'($urandom)};
		wr(8'h82, 8'(ctrl));
		@(posedge clk);
		sleepInstruction <= 1'b1;
		@(posedge clk);
		sleepInstruction <= 1'b0;
		#1 chk({cpuHalt, busClockEnable, pins}, m ? 4'h9 : 4'hE);
		if (!m) begin
			@(posedge clk);
			refreshCycle <= 1'b1;
			@(posedge clk);
			refreshCycle <= 1'b0;
			#1 chk(pins, 2'h0);
		end else begin
			// Level at the mask and the interval timer must both be ignored
			for (int j = 1; j < 4; j += 2) begin
				irqPulse(2'(j), interruptMaskLevel);
				repeat (30) @(posedge clk);
				drop <= 1'b1;
				#1 chk(pins, 2'h1);
				@(posedge clk);
				drop <= 1'b0;
			end
		end
		irqPulse(k, interruptMaskLevel + 4'h1);
		n = 0;
		while (interruptStart !== 1'b1 && n < 100) begin
			@(posedge clk);
			#1 n++;
		end
		chk(m ? (n >= s * DIV + 3 && n <= s * DIV + DIV + 2) : n == 1, 1);
		chk(interruptEventCode, code[k]);
		chk({cpuHalt, internalClockEnable, pins}, 4'h4);
	endtask : runMode

	// --------
	// Sequence
	// --------
	initial begin
		{reset_n, regWrite, regRead, sleepInstruction, blockBit, refreshCycle, fire, drop} = '0;
		{regAddr, regWriteData, interruptMaskLevel, levelValue, kind, settleCount} = '0;
		manualReset_n = 1'b1;
		code = '{pdm_pkg::EVENT_CODE_NMI, pdm_pkg::EVENT_CODE_LEVEL, pdm_pkg::EVENT_CODE_PERIPH};
		void'($urandom(83));
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		rd(8'h82, 8'h00);
		rd(8'h84, 8'h00);
		rd(8'h10, 8'h00);
		for (int i = 0; i < 8; i++) begin
			n = $urandom;
			wr(8'h82, 8'(n));
			ctrl = n & 8'h87;
			rd(8'h82, 8'(ctrl));
			chk({moduleStop, calendarAccessBlock}, 4'({ctrl[2:0], ctrl[1]}));
		end
		@(posedge clk);
		manualReset_n <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk({pins, moduleStop}, 5'h18);
		@(posedge clk);
		manualReset_n <= 1'b1;
		rd(8'h82, 8'(ctrl));
		@(posedge clk);
		reset_n <= 1'b0;
		@(posedge clk);
		#1 chk(pins, 2'h3);
		@(posedge clk);
		reset_n <= 1'b1;
		rd(8'h82, 8'h00);
		for (int m = 0; m < 2; m++)
			for (int k = 0; k < 3; k++)
				runMode(1'(m), 2'(k));
		// Standby left by a reset held over several cycles
		wr(8'h82, 8'h80);
		@(posedge clk);
		sleepInstruction <= 1'b1;
		@(posedge clk);
		sleepInstruction <= 1'b0;
		manualReset_n <= 1'b0;
		repeat (4) @(posedge clk);
		#1 chk({cpuHalt, busClockEnable, pins}, 4'h7);
		@(posedge clk);
		manualReset_n <= 1'b1;
		rd(8'h82, 8'h80);
		report_and_stop();
	end
endmodule : power_down_mode_control_tb_top
